// [dv/pfsc_pmem.sv]
// Program memory model on the fetch bus
`timescale 1ns/1ps
module pfsc_pmem (
  // Fetch bus
  input wire logic [pfsc_pkg::PC_W-1:0] addr_i,
  input wire logic req_i,
  output logic [15:0] data_o
);
  import pfsc_pkg::*;
  // Aliases past its end; an idle bus shows a pattern, not a stale word
  assign data_o = req_i ? ~addr_i[15:0] : addr_i[15:0] ^ 16'h5a5a;
endmodule

// [dv/pfsc_sva.sv]
// Concurrent checks on the program flow block ports
`timescale 1ns/1ps
module pfsc_sva #(
  parameter int PM_BYTES = pfsc_pkg::PM_DEPTH_BYTES
) (
  // Clock, reset and controls
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic ce_i,
  input wire logic stack_fault_reset_enable_i,
  input wire logic clr_full_i,
  // Flow requests
  input wire logic cmd_valid_i,
  input wire pfsc_pkg::pfsc_cmd_s cmd_i,
  input wire logic irq_take_i,
  input wire logic irq_high_i,
  input wire pfsc_pkg::pfsc_ctx_s ctx_i,
  // Outputs watched
  input wire logic [pfsc_pkg::PC_W-1:0] fetch_addr_o,
  input wire logic [15:0] instr_o,
  input wire logic ctx_load_o,
  input wire pfsc_pkg::pfsc_ctx_s ctx_o,
  input wire logic stack_full_flag_o,
  input wire logic stack_underflow_flag_o,
  input wire logic device_reset_o
);
  import pfsc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A fault in flight swallows requests, so gate on it
  sequence s_go;
    ce_i && !device_reset_o && !(stack_fault_reset_enable_i &&
      ($rose(stack_full_flag_o) || $rose(stack_underflow_flag_o)));
  endsequence
  sequence s_cmd;
    s_go ##0 cmd_valid_i && !irq_take_i;
  endsequence
  vector_sel_a: assert property (s_go ##0 irq_take_i |=>
    fetch_addr_o == ($past(irq_high_i) ? VEC_HIGH : VEC_LOW))
    else $error("wrong interrupt vector");
  goto_pc_a: assert property (s_cmd ##0 cmd_i.op == PFSC_OP_GOTO |=>
    fetch_addr_o == $past(cmd_i.target)) else $error("jump target lost");
  next_pc_a: assert property (s_cmd ##0 cmd_i.op == PFSC_OP_NEXT |=>
    fetch_addr_o == $past(fetch_addr_o) + PC_STEP) else $error("bad step");
  add_pc_a: assert property (s_cmd ##0 cmd_i.op == PFSC_OP_ADDPCL |=>
    fetch_addr_o == $past(fetch_addr_o) + $past(ctx_i.working_register))
    else $error("computed jump wrong");
  lit_ret_a: assert property (s_cmd ##0 cmd_i.op == PFSC_OP_RETLIT |=>
    ctx_load_o && ctx_o.working_register == $past(cmd_i.literal))
    else $error("literal not returned");
  load_cause_a: assert property (ctx_load_o |-> $past(cmd_valid_i) &&
    ($past(cmd_i.op) == PFSC_OP_RETLIT || $past(cmd_i.fast)))
    else $error("context load without cause");
  beyond_nop_a: assert property (ce_i && fetch_addr_o >= PM_BYTES |=>
    instr_o == NOP_WORD) else $error("fetch beyond memory not zero");
  flag_hold_a: assert property (stack_full_flag_o && !clr_full_i &&
    !por_i |=> stack_full_flag_o) else $error("full flag dropped");
  fault_reset_a: assert property (stack_fault_reset_enable_i &&
    $rose(stack_full_flag_o) |=> device_reset_o ##1 !device_reset_o)
    else $error("fault reset missing");
  quiet_fault_a: assert property (device_reset_o |->
    $past(stack_fault_reset_enable_i, 2)) else $error("reset while disabled");
endmodule
bind pfsc_top pfsc_sva #(.PM_BYTES(PM_BYTES)) u_sva (.*);

// [dv/tb.sv]
// Self-checking bench for program flow and stack control
`timescale 1ns/1ps
module tb;
  import pfsc_pkg::*;
  logic clk_i = 0, rst_i = 1, por_i = 1, ce_i = 1, clr_full_i = 0;
  logic stack_fault_reset_enable_i = 0, clr_underflow_i = 0;
  logic cmd_valid_i = 0, irq_take_i = 0, irq_high_i = 0, fetch_req_o;
  pfsc_cmd_s cmd_i = '0;
  pfsc_ctx_s ctx_i = '0, ctx_o;
  logic [PC_W-1:0] fetch_addr_o, p;
  logic [15:0] fetch_data_i, instr_o;
  logic ctx_load_o, stack_full_flag_o, stack_underflow_flag_o, device_reset_o;
  int n_errors = 0, n_checks = 0;
  initial forever #4 clk_i = ~clk_i;
  pfsc_top DUT (.*);
  pfsc_pmem u_mem (.addr_i(fetch_addr_o), .req_i(fetch_req_o),
    .data_o(fetch_data_i));
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic go(input pfsc_op_e o, input logic f, input logic [20:0] t);
    irq_take_i = 0; cmd_valid_i = 1; cmd_i = '{o, f, t, 8'h3c};
    @(posedge clk_i); #1;
  endtask
  task automatic irq(input logic h);
    cmd_valid_i = 0; irq_take_i = 1; irq_high_i = h;
    @(posedge clk_i); #1;
  endtask
  task automatic idle();
    cmd_valid_i = 0; irq_take_i = 0;
    @(posedge clk_i); #1;
  endtask
  task automatic t_flow();
    go(PFSC_OP_GOTO, 0, 21'h007ffe);
    chk(fetch_req_o, 1);
    go(PFSC_OP_NEXT, 0, 0);
    chk(fetch_addr_o, 21'h008000); chk(instr_o, 16'h8001);
    chk(fetch_req_o, 0);
    go(PFSC_OP_NEXT, 0, 0);
    chk(instr_o, NOP_WORD);
  endtask
  task automatic t_fast();
    p = fetch_addr_o; ctx_i = 24'h11a1b1; go(PFSC_OP_CALL, 1, 21'h000200);
    ctx_i = 24'h222222; go(PFSC_OP_RETURN, 1, 0);
    chk(ctx_o, 24'h11a1b1); chk(fetch_addr_o, p + 2);
    p = fetch_addr_o; ctx_i = 24'h333333; irq(0);
    chk(fetch_addr_o, VEC_LOW);
    ctx_i = 24'h444444; irq(1);
    ctx_i = '0; go(PFSC_OP_RETINT, 1, 0);
    chk(ctx_o, 24'h444444); chk(ctx_load_o, 1);
    go(PFSC_OP_RETLIT, 0, 0);
    chk(ctx_o.working_register, 8'h3c); chk(fetch_addr_o, p);
  endtask
  task automatic t_add();
    go(PFSC_OP_GOTO, 0, 21'h0001f0);
    ctx_i = 24'h00fe00; go(PFSC_OP_ADDPCL, 0, 0);
    chk(fetch_addr_o, 21'h0002ee);
    ce_i = 0; go(PFSC_OP_NEXT, 0, 0); ce_i = 1;
    chk(fetch_addr_o, 21'h0002ee);
  endtask
  task automatic t_fault();
    go(PFSC_OP_RETURN, 0, 0);
    chk(stack_underflow_flag_o, 1); chk(fetch_addr_o, 0);
    rst_i = 1; idle(); rst_i = 0; idle();
    chk(stack_underflow_flag_o, 1); chk(device_reset_o, 0);
    clr_underflow_i = 1; idle(); clr_underflow_i = 0;
    chk(stack_underflow_flag_o, 0);
    stack_fault_reset_enable_i = 1;
    repeat (32) go(PFSC_OP_CALL, 0, 21'h000100);
    chk(stack_full_flag_o, 1); idle(); chk(device_reset_o, 1);
    idle(); chk(device_reset_o, 0); chk(stack_full_flag_o, 1);
    por_i = 1; rst_i = 1; idle(); por_i = 0; rst_i = 0;
    chk(stack_full_flag_o, 0);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    #1 rst_i = 0; por_i = 0;
    t_flow(); t_fast(); t_add(); t_fault();
    close_out();
  end
  // Run needs under a hundred cycles
  initial begin
    #20000 n_errors++;
    close_out();
  end
endmodule

// [shared/pfsc_pkg.sv]
// Shared constants and types for program flow and stack control
package pfsc_pkg;
  localparam int PC_W = 21;
  localparam int PM_DEPTH_BYTES = 32768;
  localparam int STK_DEPTH = 31;
  localparam int STK_PTR_W = 5;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // Shadowed core context
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [7:0] bank_select_register;
  } pfsc_ctx_s;

  // One decoded flow operation per instruction cycle
  typedef enum logic [2:0] {
    PFSC_OP_NEXT = 3'h0,
    PFSC_OP_CALL = 3'h1,
    PFSC_OP_RETURN = 3'h2,
    PFSC_OP_RETINT = 3'h3,
    PFSC_OP_RETLIT = 3'h4,
    PFSC_OP_ADDPCL = 3'h5,
    PFSC_OP_GOTO = 3'h6
  } pfsc_op_e;

  typedef struct packed {
    pfsc_op_e op;
    logic fast;
    logic [PC_W-1:0] target;
    logic [7:0] literal;
  } pfsc_cmd_s;

  typedef enum logic [1:0] {
    PFSC_RUN = 2'b00,
    PFSC_FAULT = 2'b01,
    PFSC_RESET = 2'b11
  } pfsc_state_e;
endpackage

// [src/pfsc_top.sv]
// Program counter, return stack, fault reset and shadow register stack
`timescale 1ns/1ps
// Operation
// - The program counter is 21 bits wide and spans a 2-Mbyte byte space.
// - Fetches above implemented memory but inside 2 Mbytes return zero.
// - Instruction fetch has its own bus, apart from data memory.
// - With fault reset enabled, a stack fault sets its flag then resets.
// - With fault reset disabled, a stack fault only sets its flag.
// - Stack flags stay set until software or power-on reset clears them.
// - A one-entry shadow stack holds status, working and bank registers.
// - Every interrupt vector loads the shadow stack with current values.
// - A fast return from interrupt restores the shadowed values.
// - A high-priority entry during low-priority service overwrites it.
// - A fast call saves the context and a fast return restores it.
// - Adding the working register to the low PC byte advances the PC.
// - Return with literal loads the literal into working and pops.
module pfsc_top #(
  parameter int PM_BYTES = pfsc_pkg::PM_DEPTH_BYTES
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic ce_i,
  // Configuration and software flag clears
  input wire logic stack_fault_reset_enable_i,
  input wire logic clr_full_i,
  input wire logic clr_underflow_i,
  // Instruction flow
  input wire logic cmd_valid_i,
  input wire pfsc_pkg::pfsc_cmd_s cmd_i,
  input wire logic irq_take_i,
  input wire logic irq_high_i,
  input wire pfsc_pkg::pfsc_ctx_s ctx_i,
  // Program memory fetch bus
  output logic [pfsc_pkg::PC_W-1:0] fetch_addr_o,
  output logic fetch_req_o,
  input wire logic [15:0] fetch_data_i,
  output logic [15:0] instr_o,
  // Context write-back and status
  output logic ctx_load_o,
  output pfsc_pkg::pfsc_ctx_s ctx_o,
  output logic stack_full_flag_o,
  output logic stack_underflow_flag_o,
  output logic device_reset_o
);
  import pfsc_pkg::*;

  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [PC_W-1:0] stk_mem [STK_DEPTH];
  logic [STK_PTR_W-1:0] sp_r;
  pfsc_ctx_s shadow_register_stack_r;
  pfsc_state_e state_r;
  logic full_ev;
  logic unf_ev;
  logic push;
  logic pop;
  logic fast_restore;
  logic [15:0] instr_r;
  logic load_r;
  pfsc_ctx_s ctx_r;

  function automatic logic in_memory(input logic [PC_W-1:0] a);
    in_memory = a < PC_W'(PM_BYTES);
  endfunction

  wire run = ce_i && state_r == PFSC_RUN;
  wire take = run && irq_take_i;
  wire exec = run && !irq_take_i && cmd_valid_i;

  // Pushes and pops
  always_comb begin
    push = take || (exec && cmd_i.op == PFSC_OP_CALL);
    pop = exec && (cmd_i.op == PFSC_OP_RETURN ||
                   cmd_i.op == PFSC_OP_RETINT ||
                   cmd_i.op == PFSC_OP_RETLIT);
    full_ev = push && sp_r == STK_PTR_W'(STK_DEPTH);
    unf_ev = pop && sp_r == '0;
    fast_restore = exec && cmd_i.fast &&
                   (cmd_i.op == PFSC_OP_RETURN ||
                    cmd_i.op == PFSC_OP_RETINT);
  end

  // Next program counter; byte addressed, one word per step
  always_comb begin
    pc_nxt = pc_r + PC_STEP;
    if (take) begin
      pc_nxt = irq_high_i ? VEC_HIGH : VEC_LOW;
    end else if (exec) begin
      case (cmd_i.op)
        PFSC_OP_CALL, PFSC_OP_GOTO: pc_nxt = cmd_i.target;
        PFSC_OP_RETURN, PFSC_OP_RETINT, PFSC_OP_RETLIT: begin
          // Underflowed pop returns to zero
          pc_nxt = unf_ev ? PC_RST : stk_mem[sp_r - 1'b1];
        end
        // Carry ripples upward; software keeps the offset even
        PFSC_OP_ADDPCL: pc_nxt = pc_r + PC_W'(ctx_i.working_register);
        default: pc_nxt = pc_r + PC_STEP;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_r == PFSC_RESET) begin
      pc_r <= PC_RST;
    end else if (run && (take || exec)) begin
      pc_r <= pc_nxt;
    end
  end

  // Return address stack; a full push is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r == PFSC_RESET) begin
      sp_r <= '0;
    end else if (push && !full_ev) begin
      stk_mem[sp_r] <= take ? pc_r : pc_r + PC_STEP;
      sp_r <= sp_r + 1'b1;
    end else if (pop && !unf_ev) begin
      sp_r <= sp_r - 1'b1;
    end
  end

  // Flags survive every reset but power-on; set wins over clear
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      stack_full_flag_o <= 1'b0;
      stack_underflow_flag_o <= 1'b0;
    end else if (ce_i) begin
      if (full_ev) begin
        stack_full_flag_o <= 1'b1;
      end else if (clr_full_i) begin
        stack_full_flag_o <= 1'b0;
      end
      if (unf_ev) begin
        stack_underflow_flag_o <= 1'b1;
      end else if (clr_underflow_i) begin
        stack_underflow_flag_o <= 1'b0;
      end
    end
  end

  // Fault sequencing: flag first, reset next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= PFSC_RUN;
    end else if (ce_i) begin
      case (state_r)
        PFSC_RUN: begin
          if ((full_ev || unf_ev) && stack_fault_reset_enable_i) begin
            state_r <= PFSC_FAULT;
          end
        end
        PFSC_FAULT: state_r <= PFSC_RESET;
        PFSC_RESET: state_r <= PFSC_RUN;
        default: state_r <= PFSC_RUN;
      endcase
    end
  end

  always_comb begin
    device_reset_o = state_r == PFSC_RESET;
  end

  // Shadow stack has no software path; latest entry always wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shadow_register_stack_r <= '0;
    end else if (take) begin
      shadow_register_stack_r <= ctx_i;
    end else if (exec && cmd_i.op == PFSC_OP_CALL && cmd_i.fast) begin
      shadow_register_stack_r <= ctx_i;
    end
  end

  // Context write-back to the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_r <= 1'b0;
      ctx_r <= '0;
    end else if (ce_i) begin
      load_r <= fast_restore || (exec && cmd_i.op == PFSC_OP_RETLIT);
      ctx_r <= ctx_i;
      if (fast_restore) begin
        ctx_r <= shadow_register_stack_r;
      end
      if (exec && cmd_i.op == PFSC_OP_RETLIT) begin
        ctx_r.working_register <= cmd_i.literal;
      end
    end
  end

  // Dedicated fetch bus, independent of data memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_r <= NOP_WORD;
    end else if (ce_i) begin
      instr_r <= in_memory(pc_r) ? fetch_data_i : NOP_WORD;
    end
  end

  always_comb begin
    fetch_addr_o = pc_r;
    fetch_req_o = !rst_i && state_r == PFSC_RUN && in_memory(pc_r);
    instr_o = instr_r;
    ctx_load_o = load_r;
    ctx_o = ctx_r;
  end
endmodule
